// *** rtl/spfm_pkg.sv ***
// Function
// - Framed mode with select enable is invalid
// - Serial clock runs continuously in framed mode
// - Active sync pulse on select starts frame
// - Frame sync polarity at control two bit 13
// - Clock idle polarity at control one bit 6
// - Input sample phase settable in master mode only
// - Sample phase accepted only when written together with master enable
// - Transmission start moves buffer, buffer reads empty
// - Master waits for slave buffer before transfer; the lead wait is made only in framed or select pin mode
// - Preload transmit buffer before next transaction
package spfm_pkg;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 4;
   localparam int CNT_W = 5;
   // Register indices on the device's own register port.
   localparam logic [3:0] ADDR_CON1 = 4'h0;
   localparam logic [3:0] ADDR_CON2 = 4'h1;
   localparam logic [3:0] ADDR_BUF = 4'h2;
   localparam logic [3:0] ADDR_STAT = 4'h3;
   // Field positions in control register one and two.
   localparam int CON1_MASTER_BIT = 5;
   localparam int CON1_IDLE_POL_BIT = 6;
   localparam int CON1_SEL_EN_BIT = 7;
   localparam int CON1_PHASE_BIT = 9;
   localparam int CON2_FPOL_BIT = 13;
   localparam int CON2_FRAMED_BIT = 15;
   // Status register fields.
   localparam int STAT_TXFULL_BIT = 0;
   localparam int STAT_RXFULL_BIT = 1;
   localparam int STAT_INVALID_BIT = 2;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   // Slot 0 is the load or sync slot, slots 1 to 16 carry data MSB first.
   localparam logic [4:0] LAST_SLOT = 5'h10;
   // Timing of the clock-making end, in its own clock cycles.
   localparam int HALF_PERIOD_CYC = 4;
   localparam int START_GAP_CYC = 8;
   // Serial clock periods run with the select idle before each word when framed mode or the select pin is enabled.
   localparam int LEAD_SLOTS = 4;
   // System clock cycles the link side is kept in reset after srst.
   localparam int RST_STRETCH_CYC = 64;
endpackage

// *** rtl/spfm_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface spfm_link_if;
   logic sclk;
   logic ss;
   logic mosi;
   logic miso;
   logic idle_pol;
   modport dev (input sclk, input ss, input mosi, output miso, output idle_pol);
   modport ctl (output sclk, output ss, output mosi, input miso, input idle_pol);
endinterface
`default_nettype wire

// *** rtl/spfm_dev.sv ***
`timescale 1ns/10ps
`default_nettype none
module spfm_dev
   import spfm_pkg::*;
(
   // System clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   // Link
   spfm_link_if.dev link
);
   ////////////////////////////////////////////////////////////////////////
   logic idle_sel_q, sel_en_q, master_q, phase_q, framed_q, fpol_q;
   logic [WORD_W-1:0] tx_hold_q, rx_buf_q;
   logic tx_full_q, rx_full_q, tx_req_t_q;
   logic [15:0] rdata_q;
   logic idle_pol_q;
   logic [2:0] ack_s_q, rx_s_q;
   logic tx_ack_t_q, rx_t_q;
   logic [WORD_W-1:0] rx_word_q;
   logic ack_edge, rx_edge, buf_wr, buf_rd;

   assign buf_wr = wr && addr == ADDR_BUF;
   assign buf_rd = rd && addr == ADDR_BUF;
   assign ack_edge = ack_s_q[1] ^ ack_s_q[2];
   assign rx_edge = rx_s_q[1] ^ rx_s_q[2];

   // Control registers.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         idle_sel_q <= 1'b0;
         sel_en_q <= 1'b0;
         master_q <= 1'b0;
         phase_q <= 1'b0;
         framed_q <= 1'b0;
         fpol_q <= 1'b0;
      end
      else if (wr && addr == ADDR_CON1)
      begin
         idle_sel_q <= wdata[CON1_IDLE_POL_BIT];
         sel_en_q <= wdata[CON1_SEL_EN_BIT];
         master_q <= wdata[CON1_MASTER_BIT];
         phase_q <= wdata[CON1_PHASE_BIT] & wdata[CON1_MASTER_BIT];
      end
      else if (wr && addr == ADDR_CON2)
      begin
         framed_q <= wdata[CON2_FRAMED_BIT];
         fpol_q <= wdata[CON2_FPOL_BIT];
      end
   end

   // The clock-making end takes its resting level from here.
   always_ff @(posedge clk)
   begin
      if (srst)
         idle_pol_q <= 1'b0;
      else
         idle_pol_q <= idle_sel_q;
   end
   assign link.idle_pol = idle_pol_q;

   // Transmit holding word; writes are refused while it is still full.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tx_hold_q <= RESET_WORD;
         tx_full_q <= 1'b0;
         tx_req_t_q <= 1'b0;
      end
      else if (buf_wr && !tx_full_q)
      begin
         tx_hold_q <= wdata[WORD_W-1:0];
         tx_full_q <= 1'b1;
         tx_req_t_q <= ~tx_req_t_q;
      end
      else if (ack_edge)
         tx_full_q <= 1'b0;
   end

   // Receive buffer; a new word wins over a clearing read.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rx_buf_q <= RESET_WORD;
         rx_full_q <= 1'b0;
      end
      else if (rx_edge)
      begin
         rx_buf_q <= rx_word_q;
         rx_full_q <= 1'b1;
      end
      else if (buf_rd)
         rx_full_q <= 1'b0;
   end

   // Toggle crossings from the link domain.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ack_s_q <= 3'h0;
         rx_s_q <= 3'h0;
      end
      else
      begin
         ack_s_q <= {ack_s_q[1:0], tx_ack_t_q};
         rx_s_q <= {rx_s_q[1:0], rx_t_q};
      end
   end

   // Read data one cycle after the strobe; unmapped reads return zero.
   always_ff @(posedge clk)
   begin
      if (srst)
         rdata_q <= 16'h0000;
      else if (rd)
      begin
         rdata_q <= 16'h0000;
         case (addr)
            ADDR_CON1:
            begin
               rdata_q[CON1_MASTER_BIT] <= master_q;
               rdata_q[CON1_IDLE_POL_BIT] <= idle_sel_q;
               rdata_q[CON1_SEL_EN_BIT] <= sel_en_q;
               rdata_q[CON1_PHASE_BIT] <= phase_q;
            end
            ADDR_CON2:
            begin
               rdata_q[CON2_FRAMED_BIT] <= framed_q;
               rdata_q[CON2_FPOL_BIT] <= fpol_q;
            end
            ADDR_BUF: rdata_q[WORD_W-1:0] <= rx_buf_q;
            ADDR_STAT:
            begin
               rdata_q[STAT_TXFULL_BIT] <= tx_full_q;
               rdata_q[STAT_RXFULL_BIT] <= rx_full_q;
               rdata_q[STAT_INVALID_BIT] <= framed_q & sel_en_q;
            end
            default: rdata_q <= 16'h0000;
         endcase
      end
   end
   assign rdata = rdata_q;

   // Stretches reset so the link side sees it on enough serial clock edges.
   logic [7:0] rst_cnt_q;
   logic rst_req_q;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rst_cnt_q <= 8'(RST_STRETCH_CYC);
         rst_req_q <= 1'b1;
      end
      else
      begin
         if (rst_cnt_q != 8'h00)
            rst_cnt_q <= rst_cnt_q - 8'h01;
         rst_req_q <= rst_cnt_q != 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link domain, clocked by the serial clock.
   logic [2:0] rst_s_q;
   logic [1:0] cfg_a_q [4];
   logic [3:0] cfg_b_q;
   logic lrst, l_framed, l_fpol, l_sel_en, l_req;
   logic [CNT_W-1:0] cnt_q;
   logic [WORD_W-1:0] shift_q;
   logic miso_q, sync_act, selected, load, pending;
   logic [3:0] cfg_in;

   assign cfg_in = {tx_req_t_q, sel_en_q, fpol_q, framed_q};

   always_ff @(posedge link.sclk)
   begin
      rst_s_q <= {rst_s_q[1:0], rst_req_q};
   end
   assign lrst = rst_s_q[2];

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_cfg_sync
         always_ff @(posedge link.sclk)
         begin
            if (lrst)
            begin
               cfg_a_q[gi] <= 2'h0;
               cfg_b_q[gi] <= 1'b0;
            end
            else
            begin
               cfg_a_q[gi] <= {cfg_a_q[gi][0], cfg_in[gi]};
               cfg_b_q[gi] <= cfg_a_q[gi][1];
            end
         end
      end
   endgenerate
   assign l_framed = cfg_b_q[0];
   assign l_fpol = cfg_b_q[1];
   assign l_sel_en = cfg_b_q[2];
   assign l_req = cfg_b_q[3];

   assign pending = l_req != tx_ack_t_q;
   assign sync_act = l_framed && (link.ss == l_fpol);
   assign selected = l_framed || !l_sel_en || !link.ss;
   // A free-running clock lets the sync slot and every data bit be sampled.
   assign load = l_framed ? sync_act : (selected && cnt_q == '0);

   always_ff @(posedge link.sclk)
   begin
      if (lrst)
      begin
         cnt_q <= '0;
         shift_q <= RESET_WORD;
         tx_ack_t_q <= 1'b0;
         rx_t_q <= 1'b0;
         rx_word_q <= RESET_WORD;
      end
      else if (!selected)
         cnt_q <= '0;
      else if (load)
      begin
         shift_q <= pending ? tx_hold_q : RESET_WORD;
         tx_ack_t_q <= tx_ack_t_q ^ pending;
         cnt_q <= CNT_W'(1);
      end
      else if (cnt_q != '0)
      begin
         shift_q <= {shift_q[WORD_W-2:0], link.mosi};
         if (cnt_q == LAST_SLOT)
         begin
            cnt_q <= '0;
            rx_word_q <= {shift_q[WORD_W-2:0], link.mosi};
            rx_t_q <= ~rx_t_q;
         end
         else
            cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   // Output changes on the falling edge so the far end samples it on the rise.
   always_ff @(negedge link.sclk)
   begin
      if (lrst)
         miso_q <= 1'b0;
      else
         miso_q <= shift_q[WORD_W-1];
   end
   assign link.miso = miso_q;
endmodule // spfm_dev
`default_nettype wire

// *** rtl/spfm_ctl.sv ***
`timescale 1ns/10ps
`default_nettype none
module spfm_ctl
   import spfm_pkg::*;
#(
   parameter int HALF = HALF_PERIOD_CYC,
   parameter int GAP = START_GAP_CYC
)
(
   // System clock and reset
   input wire logic clk,
   input wire logic srst,
   // Configuration
   input wire logic framed_mode_enable,
   input wire logic frame_sync_polarity,
   input wire logic slave_select_pin_enable,
   // Transfer request and result
   input wire logic start,
   input wire logic [WORD_W-1:0] tx_word,
   output logic busy,
   output logic [WORD_W-1:0] rx_word,
   output logic rx_valid,
   // Link
   spfm_link_if.ctl link
);
   typedef enum {ST_IDLE, ST_LEAD, ST_RUN, ST_FIN} spfm_state_t;
   spfm_state_t state_q;
   logic [3:0] lead_q;
   logic [7:0] div_q, gap_q;
   logic [1:0] miso_s_q, pol_s_q;
   logic tick, sclk_q, ss_q, mosi_q, busy_q, rx_valid_q;
   logic [CNT_W-1:0] slot_q;
   logic [WORD_W-1:0] tx_q, rx_q;
   logic ss_act, ss_data, ss_idle;

   assign tick = div_q == 8'(HALF - 1);
   assign ss_idle = framed_mode_enable ? ~frame_sync_polarity : 1'b1;
   assign ss_act = framed_mode_enable ? frame_sync_polarity : !slave_select_pin_enable;
   assign ss_data = framed_mode_enable ? ~frame_sync_polarity : !slave_select_pin_enable;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         div_q <= 8'h00;
         miso_s_q <= 2'h0;
         pol_s_q <= 2'h0;
      end
      else
      begin
         div_q <= tick ? 8'h00 : div_q + 8'h01;
         miso_s_q <= {miso_s_q[0], link.miso};
         pol_s_q <= {pol_s_q[0], link.idle_pol};
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_q <= ST_IDLE;
         sclk_q <= 1'b0;
         ss_q <= 1'b1;
         mosi_q <= 1'b0;
         slot_q <= '0;
         tx_q <= RESET_WORD;
         rx_q <= RESET_WORD;
         rx_valid_q <= 1'b0;
         gap_q <= 8'h00;
         lead_q <= 4'h0;
      end
      else
      begin
         rx_valid_q <= 1'b0;
         case (state_q)
            ST_IDLE:
            begin
               if (gap_q != 8'h00)
                  gap_q <= gap_q - 8'h01;
               ss_q <= ss_idle;
               if (tick)
                  sclk_q <= framed_mode_enable ? ~sclk_q : pol_s_q[1];
               if (start && gap_q == 8'h00)
               begin
                  tx_q <= tx_word;
                  slot_q <= '0;
                  mosi_q <= 1'b0;
                  lead_q <= 4'(LEAD_SLOTS);
                  // Lead periods let the far end take its buffer and settings.
                  state_q <= (framed_mode_enable || slave_select_pin_enable) ? ST_LEAD : ST_RUN;
               end
            end
            ST_LEAD:
            begin
               if (tick && !sclk_q)
               begin
                  sclk_q <= 1'b1;
                  lead_q <= lead_q - 4'h1;
               end
               else if (tick && lead_q == 4'h0)
               begin
                  sclk_q <= 1'b0;
                  ss_q <= ss_act;
                  state_q <= ST_RUN;
               end
               else if (tick)
                  sclk_q <= 1'b0;
            end
            ST_RUN:
            begin
               if (tick && !sclk_q)
               begin
                  sclk_q <= 1'b1;
                  if (slot_q != '0)
                     rx_q <= {rx_q[WORD_W-2:0], miso_s_q[1]};
                  if (slot_q == LAST_SLOT)
                     state_q <= ST_FIN;
                  else
                     slot_q <= slot_q + CNT_W'(1);
               end
               else if (tick)
               begin
                  sclk_q <= 1'b0;
                  if (slot_q != '0)
                  begin
                     ss_q <= ss_data;
                     mosi_q <= tx_q[WORD_W - int'(slot_q)];
                  end
               end
            end
            ST_FIN:
            begin
               if (tick)
               begin
                  sclk_q <= (framed_mode_enable || !pol_s_q[1]) ? 1'b0 : 1'b1;
                  ss_q <= ss_idle;
                  mosi_q <= 1'b0;
                  rx_valid_q <= 1'b1;
                  gap_q <= 8'(GAP);
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         busy_q <= 1'b0;
      else
         busy_q <= state_q != ST_IDLE || gap_q != 8'h00 || (start && state_q == ST_IDLE);
   end

   assign busy = busy_q;
   assign rx_word = rx_q;
   assign rx_valid = rx_valid_q;
   assign link.sclk = sclk_q;
   assign link.ss = ss_q;
   assign link.mosi = mosi_q;
endmodule // spfm_ctl
`default_nettype wire

// *** tb/spfm_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module spfm_props
   import spfm_pkg::*;
#(
   parameter int HALF = HALF_PERIOD_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Link
   input wire logic sclk,
   input wire logic ss,
   input wire logic idle_pol,
   // Clock-making end
   input wire logic framed_mode_enable,
   input wire logic frame_sync_polarity,
   input wire logic start,
   input wire logic busy,
   input wire logic rx_valid,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata
);
   localparam int TOG = 2 * HALF;
   localparam int SLOT = 2 * HALF + 1;
   localparam int LEADC = (2 * LEAD_SLOTS + 3) * HALF;
   localparam int WMIN = (2 * LEAD_SLOTS + 32) * HALF;
   localparam int WMAX = (2 * LEAD_SLOTS + 38) * HALF;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////////
   a_sclk_runs: assert property (framed_mode_enable |-> ##[1:TOG] $changed(sclk))
      else $error("serial clock stalled in framed mode");
   a_sync_at_start: assert property (start && !busy && framed_mode_enable
      |-> ##[0:LEADC] ss == frame_sync_polarity) else $error("no sync pulse after start");
   a_sync_one_slot: assert property (framed_mode_enable && $changed(ss)
      && ss == frame_sync_polarity |-> ##[1:SLOT] ss != frame_sync_polarity)
      else $error("sync pulse too long");
   a_word_length: assert property (start && !busy |-> ##[WMIN:WMAX] rx_valid)
      else $error("word did not complete in time");
   a_sclk_idle_level: assert property ((!framed_mode_enable && !busy
      && $stable(idle_pol))[*8] |-> sclk == idle_pol) else $error("wrong clock rest level");
   a_idle_pol_write: assert property (wr && addr == ADDR_CON1
      |-> ##2 idle_pol == $past(wdata[CON1_IDLE_POL_BIT], 2))
      else $error("clock rest level not taken from write");
   a_phase_needs_master: assert property (rd && addr == ADDR_CON1
      |=> !rdata[CON1_PHASE_BIT] || rdata[CON1_MASTER_BIT])
      else $error("sample phase set without master mode");
   a_frame_ends_idle: assert property (rx_valid && framed_mode_enable
      |-> ss != frame_sync_polarity) else $error("sync still active at word end");
endmodule // spfm_props
`default_nettype wire

// *** tb/tb_spi_frame_and_master_setup.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_spi_frame_and_master_setup;
   import spfm_pkg::*;
   logic clk, srst, wr, rd, fr, pol, sel, start, busy, rx_valid;
   logic [ADDR_W-1:0] addr;
   logic [15:0] wdata, rdata, v;
   logic [WORD_W-1:0] tx_word, rx_word;
   int error_cnt, num_checks, cyc;
   spfm_link_if link_if();
   spfm_dev spfm_dev_inst (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .link(link_if));
   spfm_ctl #(.HALF(4), .GAP(8)) spfm_ctl_inst (.clk(clk), .srst(srst),
      .framed_mode_enable(fr), .frame_sync_polarity(pol), .slave_select_pin_enable(sel),
      .start(start), .tx_word(tx_word), .busy(busy), .rx_word(rx_word),
      .rx_valid(rx_valid), .link(link_if));
   spfm_props #(.HALF(4)) spfm_props_inst (.clk(clk), .srst(srst), .sclk(link_if.sclk),
      .ss(link_if.ss), .idle_pol(link_if.idle_pol), .framed_mode_enable(fr),
      .frame_sync_polarity(pol), .start(start), .busy(busy), .rx_valid(rx_valid),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
      #1;
   endtask
   task automatic reg_rd(input logic [3:0] a);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1;
      v = rdata;
   endtask
   // The device end is loaded first, then one word is swapped both ways.
   task automatic xfer(input logic [15:0] c, input logic [15:0] d);
      int n;
      reg_wr(ADDR_BUF, d);
      reg_rd(ADDR_STAT);
      check(v & 16'h0001, 16'h0001);
      start <= 1'h1;
      tx_word <= c;
      @(posedge clk);
      start <= 1'h0;
      n = 0;
      while (rx_valid !== 1'h1 && n < 400)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      check(rx_word, d);
      while (busy !== 1'h0 && n < 440)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      reg_rd(ADDR_STAT);
      check(v & 16'h0003, 16'h0002);
      reg_rd(ADDR_BUF);
      check(v, c);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_framed;
      for (int p = 0; p < 2; p++)
      begin
         fr <= 1'h1;
         pol <= p[0];
         reg_wr(ADDR_CON2, {1'h1, 1'h0, p[0], 13'h0000});
         reg_wr(ADDR_CON1, 16'h0000);
         xfer(p[0] ? 16'hFFFE : 16'h8001, p[0] ? 16'h7FFF : 16'h0001);
         check({15'h0000, link_if.ss}, {15'h0000, ~p[0]});
      end
   endtask
   task automatic t_select;
      fr <= 1'h0;
      sel <= 1'h1;
      reg_wr(ADDR_CON2, 16'h0000);
      reg_wr(ADDR_CON1, 16'h00C0);
      @(posedge clk);
      #1;
      check({15'h0000, link_if.idle_pol}, 16'h0001);
      xfer(16'hA5C3, 16'h3C5A);
      reg_wr(ADDR_CON1, 16'h0080);
      @(posedge clk);
      #1;
      check({15'h0000, link_if.idle_pol}, 16'h0000);
      reg_rd(ADDR_STAT);
      check(v & 16'h0004, 16'h0000);
      reg_wr(ADDR_CON2, 16'h8000);
      reg_rd(ADDR_STAT);
      check(v & 16'h0004, 16'h0004);
      reg_wr(ADDR_CON1, 16'h0000);
   endtask
   task automatic t_phase;
      reg_wr(ADDR_CON1, 16'h0200);
      reg_rd(ADDR_CON1);
      check(v & 16'h0220, 16'h0000);
      reg_wr(ADDR_CON1, 16'h0220);
      reg_rd(ADDR_CON1);
      check(v & 16'h0220, 16'h0220);
      reg_wr(ADDR_CON1, 16'h0000);
      reg_rd(ADDR_CON1);
      check(v & 16'h0220, 16'h0000);
      reg_rd(4'hF);
      check(v, 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   initial
   begin
      {wr, rd, pol, sel, start} = 5'h00;
      {srst, fr} = 2'h3;
      addr = 4'h0;
      wdata = 16'h0000;
      tx_word = 16'h0000;
      repeat (10) @(posedge clk);
      srst <= 1'h0;
      // The device's link side leaves reset only on running serial clock edges.
      repeat (16) @(posedge link_if.sclk);
      @(posedge clk);
      #1;
      t_framed();
      t_phase();
      t_select();
      print_verdict();
   end
endmodule // tb_spi_frame_and_master_setup
`default_nettype wire
